/* File: dv/fbp_array_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// array model: answers each line read after lat cycles (one cycle when lat is 0)
// ------------------------------------------------------------
module fbp_array_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic arr_req,
  input wire logic [15:0] arr_line,
  input wire logic [3:0] lat,
  output logic arr_valid,
  output logic [255:0] arr_data,
  output logic [15:0] seen_line
);
  logic busy;
  logic [3:0] cnt;
  function automatic logic [63:0] beat(input logic [15:0] l,
    input logic [1:0] b);
    return {l, 14'h0, b, ~l, 16'h5A5A};
  endfunction
  function automatic logic [255:0] line(input logic [15:0] l);
    return {beat(l, 2'h3), beat(l, 2'h2), beat(l, 2'h1), beat(l, 2'h0)};
  endfunction
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      cnt <= 4'h0;
      arr_valid <= 1'b0;
      arr_data <= '0;
      seen_line <= 16'h0;
    end else begin
      arr_valid <= 1'b0;
      arr_data <= ~arr_data;
      if (arr_req) begin
        seen_line <= arr_line;
        busy <= (lat > 4'h1);
        cnt <= lat - 4'h1;
        if (lat <= 4'h1) begin
          arr_valid <= 1'b1;
          arr_data <= line(arr_line);
        end
      end else if (busy && cnt == 4'h1) begin
        busy <= 1'b0;
        arr_valid <= 1'b1;
        arr_data <= line(seen_line);
      end else if (busy) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule // fbp_array_model
`default_nettype wire

/* File: dv/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int TMO = 20000;
  localparam logic [7:0] PF_CTL [8] = '{8'h31, 8'h30, 8'h3B, 8'h3B,
    8'h11, 8'h11, 8'h21, 8'h21};
  localparam logic [1:0] PF_MST [8] = '{2'h0, 2'h0, 2'h1, 2'h2,
    2'h0, 2'h0, 2'h3, 2'h3};
  localparam logic PF_INS [8] = '{1'b0, 1'b1, 1'b1, 1'b0,
    1'b0, 1'b1, 1'b1, 1'b0};
  localparam int PF_WAIT [8] = '{0, 3, 3, 0, 3, 0, 3, 0};
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic rd_req, rd_instr, rd_ready, rd_ack, rd_err;
  logic [20:0] rd_addr;
  logic [1:0] rd_master;
  logic [63:0] rd_data;
  logic arr_req, arr_valid;
  logic [15:0] arr_line, seen_line;
  logic [255:0] arr_data;
  logic [3:0] lat;
  int errors, n_tests, cyc;
  fbp_flash_bus_port dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_master(rd_master), .rd_instr(rd_instr), .rd_ready(rd_ready),
    .rd_ack(rd_ack), .rd_err(rd_err), .rd_data(rd_data),
    .arr_req(arr_req), .arr_line(arr_line), .arr_valid(arr_valid),
    .arr_data(arr_data));
  fbp_array_model u_arr (.clk(hclk), .rst_n(hresetn), .arr_req(arr_req),
    .arr_line(arr_line), .lat(lat), .arr_valid(arr_valid),
    .arr_data(arr_data), .seen_line(seen_line));
  // ------------------------------------------------------------
  // checks and report
  // ------------------------------------------------------------
  task automatic chk_val(input string what, input logic [63:0] exp,
    input logic [63:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_wait(input string what, input int exp, input int got);
    n_tests++;
    if (got != exp) begin
      errors++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic stop_test;
    $display("counts: %0d compares, %0d mismatches", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic logic [63:0] beat(input logic [15:0] l,
    input logic [1:0] b);
    return {l, 14'h0, b, ~l, 16'h5A5A};
  endfunction
  // ------------------------------------------------------------
  // bus tasks
  // ------------------------------------------------------------
  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    chk_val("response", 64'h0, {63'h0, hresp});
  endtask
  task automatic rd_chk(input logic [20:0] a, input logic [1:0] m,
    input logic ins, input int ew);
    int w;
    @(posedge hclk);
    rd_req <= 1'b1;
    rd_addr <= a;
    rd_master <= m;
    rd_instr <= ins;
    do @(negedge hclk); while (rd_ready !== 1'b1);
    @(posedge hclk);
    rd_req <= 1'b0;
    w = -1;
    do begin
      @(negedge hclk);
      w++;
    end while (rd_ack !== 1'b1);
    chk_wait("wait states", ew, w);
    if (a >= 21'h18_0000) begin
      chk_val("error data", 64'h0, rd_data);
      chk_val("error flag", 64'h1, {63'h0, rd_err});
    end else begin
      chk_val("beat", beat(a[20:5], a[4:3]), rd_data);
      chk_val("error flag", 64'h0, {63'h0, rd_err});
    end
  endtask
  // ------------------------------------------------------------
  // clock, timeout, tests
  // ------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc++;
    if (cyc == TMO) begin
      errors++;
      stop_test();
    end
  end
  initial begin
    logic [31:0] q;
    logic [20:0] a;
    {hresetn, hsel, hwrite, rd_req, rd_instr} = '0;
    {haddr, hwdata, rd_addr, rd_master, htrans} = '0;
    hsize = 3'b010;
    lat = 4'h1;
    {errors, n_tests, cyc} = '0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    chk_val("read ready", 64'h1, {63'h0, rd_ready});
    ahb(1'b0, fbp_pkg::OFF_CTRL, 32'h0, q);
    chk_val("ctrl reset", {58'h0, fbp_pkg::CTRL_RST}, {32'h0, q});
    ahb(1'b0, fbp_pkg::OFF_STATUS, 32'h0, q);
    chk_val("status at reset", 64'h0, {60'h0, q[3:0]});
    ahb(1'b1, 8'h40, 32'hFFFF_FFFF, q);
    ahb(1'b0, 8'h40, 32'h0, q);
    chk_val("unmapped", 64'h0, {32'h0, q});
    $display("test reset and registers done");
    rd_chk(21'h00010, 2'h0, 1'b0, 3);
    chk_val("array line", 64'h0, {48'h0, seen_line});
    idle(8);
    for (int b = 0; b < 4; b++) begin
      rd_chk(21'h00020 + 21'(b * 8), 2'h0, 1'b1, 0);
    end
    idle(8);
    ahb(1'b0, fbp_pkg::OFF_STATUS, 32'h0, q);
    chk_val("two buffers", 64'h3, {62'h0, q[1:0]});
    lat <= 4'h3;
    rd_chk(21'h01008, 2'h1, 1'b0, 5);
    chk_val("array line", 64'h80, {48'h0, seen_line});
    idle(10);
    lat <= 4'h1;
    rd_chk(21'h17FFF8, 2'h0, 1'b0, 3);
    rd_chk(21'h180000, 2'h0, 1'b0, 0);
    $display("test demand path done");
    for (int i = 0; i < 8; i++) begin
      idle(6);
      ahb(1'b1, fbp_pkg::OFF_CTRL, {24'h0, PF_CTL[i] | 8'h40}, q);
      ahb(1'b0, fbp_pkg::OFF_CTRL, 32'h0, q);
      chk_val("ctrl", {56'h0, PF_CTL[i]}, {32'h0, q});
      ahb(1'b0, fbp_pkg::OFF_STATUS, 32'h0, q);
      chk_val("valid after flush", 64'h0, {62'h0, q[1:0]});
      a = 21'h04000 + 21'(i * 512);
      rd_chk(a, PF_MST[i], PF_INS[i], 3);
      idle(8);
      a = a + 21'h20;
      rd_chk(a, PF_MST[i], PF_INS[i], PF_WAIT[i]);
    end
    ahb(1'b0, fbp_pkg::OFF_HITS, 32'h0, q);
    chk_val("hit count", 64'h8, {32'h0, q});
    ahb(1'b0, fbp_pkg::OFF_MISSES, 32'h0, q);
    chk_val("miss count", 64'hF, {32'h0, q});
    $display("test prefetch triggers done");
    stop_test();
  end
endmodule // tb
`default_nettype wire

/* File: hw/fbp_ahb_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module fbp_ahb_regs (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  fbp_cfg_if.regs cfg
);
  logic [5:0] ctrl;
  logic wr_ph;
  logic [7:0] wr_off;
  logic acc;

  function automatic logic [31:0] rd_word(input logic [7:0] off);
    case (off)
      fbp_pkg::OFF_CTRL: rd_word = {26'h0, ctrl};
      fbp_pkg::OFF_STATUS: rd_word = {28'h0, cfg.pf_pend, cfg.busy,
        cfg.valid};
      fbp_pkg::OFF_HITS: rd_word = {16'h0, cfg.hits};
      fbp_pkg::OFF_MISSES: rd_word = {16'h0, cfg.misses};
      default: rd_word = 32'h0;
    endcase
  endfunction

  // ------------------------------------------------------------
  // bus phases
  // ------------------------------------------------------------
  assign acc = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph <= 1'b0;
      wr_off <= 8'h00;
    end else if (hready) begin
      wr_ph <= acc && hwrite;
      wr_off <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (acc && !hwrite) begin
      hrdata <= rd_word(haddr[7:0]);
    end
  end

  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= fbp_pkg::CTRL_RST;
      cfg.flush <= 1'b0;
    end else begin
      cfg.flush <= wr_ph && (wr_off == fbp_pkg::OFF_CTRL) &&
        hwdata[fbp_pkg::CTRL_FLUSH];
      if (wr_ph && (wr_off == fbp_pkg::OFF_CTRL)) begin
        ctrl <= hwdata[5:0];
      end
    end
  end

  assign cfg.pf_en = ctrl[fbp_pkg::CTRL_PF_EN]; // [RULE7]
  assign cfg.lim_en = ctrl[fbp_pkg::CTRL_LIM_EN]; // [RULE8]
  assign cfg.lim_mst = ctrl[fbp_pkg::CTRL_LIM_MST +: 2];
  assign cfg.instr_en = ctrl[fbp_pkg::CTRL_INSTR_EN]; // [RULE9]
  assign cfg.data_en = ctrl[fbp_pkg::CTRL_DATA_EN];
endmodule // fbp_ahb_regs
`default_nettype wire

/* File: hw/fbp_flash_bus_port.sv */
// Register access over AHB-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RULE1 - read data goes back to bus masters 64 bits wide
// RULE2 - each array read returns one whole 256-bit line
// RULE3 - exactly two 256-bit line buffers hold fetched lines
// RULE4 - prefetcher fetches the next sequential line ahead of demand
// RULE5 - a buffer hit answers with zero wait states
// RULE6 - a miss registers array data and answers after three waits
// RULE7 - prefetch starts automatically, no per-access software request
// RULE8 - prefetch triggering can be limited to one selected master
// RULE9 - instruction and data triggering are enabled separately
// RULE10 - a 1.5 Mbyte array space is decoded for fetches and reads
// RULE11 - array is 64-bit words, four words make one line
// RULE12 - low address bits pick the 64-bit beat within the line
// RULE13 - each buffer has valid and tag, cleared at reset (reset here clears only valid; tag has no reset)
module fbp_flash_bus_port (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic rd_req,
  input wire logic [20:0] rd_addr,
  input wire logic [1:0] rd_master,
  input wire logic rd_instr,
  output logic rd_ready,
  output logic rd_ack,
  output logic rd_err,
  output logic [63:0] rd_data,
  output logic arr_req,
  output logic [15:0] arr_line,
  input wire logic arr_valid,
  input wire logic [255:0] arr_data
);
  fbp_pkg::fbp_state_t state;
  fbp_buf_if bi ();
  fbp_cfg_if cfg ();

  logic idle;
  logic take;
  logic in_range;
  logic hit_now;
  logic miss_now;
  logic serve;
  logic [20:0] req_addr;
  logic [1:0] req_mst;
  logic req_ins;
  logic [20:0] cur_addr;
  logic [1:0] cur_mst;
  logic cur_ins;
  logic [15:0] cur_line;
  logic [1:0] cur_beat;
  logic [63:0] beat_word;
  logic pf_pend;
  logic [15:0] pf_line;
  logic pf_set;
  logic pf_go;
  logic pf_drop;
  logic [15:0] hits;
  logic [15:0] misses;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [63:0] beat_of(input logic [255:0] line,
    input logic [1:0] sel);
    beat_of = line[sel*64 +: 64];
  endfunction

  function automatic logic pf_ok(input logic [1:0] mst,
    input logic ins);
    pf_ok = cfg.pf_en && (!cfg.lim_en || (mst == cfg.lim_mst)) &&
      (ins ? cfg.instr_en : cfg.data_en);
  endfunction

  // ------------------------------------------------------------
  // submodules
  // ------------------------------------------------------------
  fbp_line_buf u_buf (
    .clk(hclk),
    .rst_n(hresetn),
    .bi(bi)
  );

  fbp_ahb_regs u_regs (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hwdata(hwdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .cfg(cfg)
  );

  // ------------------------------------------------------------
  // request decode
  // ------------------------------------------------------------
  assign idle = (state == fbp_pkg::FBP_IDLE);
  assign rd_ready = idle;
  assign take = rd_req && idle;
  assign in_range = rd_addr < fbp_pkg::ARR_BYTES; // [RULE10]
  assign hit_now = take && in_range && bi.look_hit; // [RULE5]
  assign miss_now = take && in_range && !bi.look_hit;
  assign serve = hit_now || (state == fbp_pkg::FBP_DSEND);

  assign cur_addr = idle ? rd_addr : req_addr;
  assign cur_mst = idle ? rd_master : req_mst;
  assign cur_ins = idle ? rd_instr : req_ins;
  assign cur_line = cur_addr[20:5]; // [RULE11]
  assign cur_beat = cur_addr[4:3]; // [RULE12]
  assign beat_word = beat_of(bi.look_data, cur_beat); // [RULE12]

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_addr <= 21'h0;
      req_mst <= 2'h0;
      req_ins <= 1'b0;
    end else if (take) begin
      req_addr <= rd_addr;
      req_mst <= rd_master;
      req_ins <= rd_instr;
    end
  end

  // ------------------------------------------------------------
  // line buffer hookup
  // ------------------------------------------------------------
  assign bi.look_line = cur_line;
  assign bi.peek_line = pf_line;
  assign bi.touch = serve;
  assign bi.flush = cfg.flush;
  assign bi.fill_en = arr_valid && !idle &&
    (state != fbp_pkg::FBP_DSEND); // [RULE6]
  assign bi.fill_line = arr_line;
  assign bi.fill_data = arr_data; // [RULE2]

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= fbp_pkg::FBP_IDLE;
    end else begin
      case (state)
        fbp_pkg::FBP_IDLE: begin
          if (miss_now) begin
            state <= fbp_pkg::FBP_DWAIT;
          end else if (pf_go) begin
            state <= fbp_pkg::FBP_PWAIT;
          end
        end
        fbp_pkg::FBP_DWAIT: begin
          if (arr_valid) begin
            state <= fbp_pkg::FBP_DSEND; // [RULE6]
          end
        end
        fbp_pkg::FBP_DSEND: begin
          state <= fbp_pkg::FBP_IDLE;
        end
        fbp_pkg::FBP_PWAIT: begin
          if (arr_valid) begin
            state <= fbp_pkg::FBP_IDLE;
          end
        end
        default: begin
          state <= fbp_pkg::FBP_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // array request
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      arr_req <= 1'b0;
      arr_line <= 16'h0;
    end else begin
      arr_req <= miss_now || pf_go; // [RULE2]
      if (miss_now) begin
        arr_line <= cur_line;
      end else if (pf_go) begin
        arr_line <= pf_line; // [RULE4]
      end
    end
  end

  // ------------------------------------------------------------
  // answer to the bus
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ack <= 1'b0;
      rd_err <= 1'b0;
      rd_data <= 64'h0;
    end else begin
      rd_ack <= serve || (take && !in_range);
      rd_err <= take && !in_range; // [RULE10]
      if (serve) begin
        rd_data <= beat_word; // [RULE1]
      end else if (take && !in_range) begin
        rd_data <= 64'h0;
      end
    end
  end

  // ------------------------------------------------------------
  // prefetch control
  // ------------------------------------------------------------
  assign pf_set = serve && pf_ok(cur_mst, cur_ins) && // [RULE8] [RULE9]
    (cur_line != fbp_pkg::LAST_LINE);
  assign pf_go = idle && !rd_req && pf_pend && !bi.peek_hit; // [RULE7]
  assign pf_drop = idle && !rd_req && pf_pend && bi.peek_hit;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pf_pend <= 1'b0;
      pf_line <= 16'h0;
    end else if (pf_set) begin
      pf_pend <= 1'b1; // [RULE7]
      pf_line <= cur_line + 16'h1; // [RULE4]
    end else if (pf_go || pf_drop || cfg.flush) begin
      pf_pend <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // statistics and status
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hits <= 16'h0;
      misses <= 16'h0;
    end else begin
      if (hit_now) begin
        hits <= hits + 16'h1;
      end
      if (miss_now) begin
        misses <= misses + 16'h1;
      end
    end
  end

  assign cfg.valid = bi.valid;
  assign cfg.busy = !idle;
  assign cfg.pf_pend = pf_pend;
  assign cfg.hits = hits;
  assign cfg.misses = misses;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  property p_hit_zero;
    @(posedge hclk) disable iff (!hresetn)
      hit_now |=> rd_ack && !rd_err;
  endproperty
  a_hit_zero: assert property (p_hit_zero) // [RULE5]
    else $error("buffer hit not answered next cycle");

  property p_miss_three;
    @(posedge hclk) disable iff (!hresetn)
      miss_now ##1 arr_req ##1 arr_valid |->
        !rd_ack ##1 !rd_ack ##1 rd_ack;
  endproperty
  a_miss_three: assert property (p_miss_three) // [RULE6]
    else $error("miss answer not after three wait states");

  property p_arr_pulse;
    @(posedge hclk) disable iff (!hresetn)
      arr_req |=> !arr_req;
  endproperty
  a_arr_pulse: assert property (p_arr_pulse) // [RULE2]
    else $error("array request longer than one cycle");

  property p_beat;
    @(posedge hclk) disable iff (!hresetn)
      hit_now |=> rd_data == $past(bi.look_data[rd_addr[4:3]*64 +: 64]);
  endproperty
  a_beat: assert property (p_beat) // [RULE12]
    else $error("wrong beat returned on hit");

  property p_range;
    @(posedge hclk) disable iff (!hresetn)
      take && !in_range |=> rd_ack && rd_err && (rd_data == 64'h0);
  endproperty
  a_range: assert property (p_range) // [RULE10]
    else $error("out of range read not refused");

  property p_pf_auto;
    @(posedge hclk) disable iff (!hresetn)
      serve && cfg.pf_en && cfg.instr_en && cfg.data_en &&
      !cfg.lim_en && (cur_line != fbp_pkg::LAST_LINE) |=> pf_pend;
  endproperty
  a_pf_auto: assert property (p_pf_auto) // [RULE7]
    else $error("prefetch not armed by served access");

  property p_pf_next;
    @(posedge hclk) disable iff (!hresetn)
      pf_set |=> pf_line == $past(cur_line) + 16'h1;
  endproperty
  a_pf_next: assert property (p_pf_next) // [RULE4]
    else $error("prefetch line is not the next line");

  property p_pf_issue;
    @(posedge hclk) disable iff (!hresetn)
      pf_go |=> arr_req && (arr_line == $past(pf_line)) ##1
        (state == fbp_pkg::FBP_PWAIT);
  endproperty
  a_pf_issue: assert property (p_pf_issue) // [RULE4]
    else $error("pending prefetch not issued");

  property p_pf_master;
    @(posedge hclk) disable iff (!hresetn)
      pf_set && cfg.lim_en |-> cur_mst == cfg.lim_mst;
  endproperty
  a_pf_master: assert property (p_pf_master) // [RULE8]
    else $error("prefetch triggered by unselected master");

  property p_pf_kind;
    @(posedge hclk) disable iff (!hresetn)
      pf_set |-> (cur_ins ? cfg.instr_en : cfg.data_en);
  endproperty
  a_pf_kind: assert property (p_pf_kind) // [RULE9]
    else $error("prefetch triggered by disabled access kind");

  property p_fill;
    @(posedge hclk) disable iff (!hresetn)
      bi.fill_en && !cfg.flush |=> bi.valid[$past(bi.fill_idx)] &&
        (bi.fill_idx != $past(bi.fill_idx));
  endproperty
  a_fill: assert property (p_fill) // [RULE13] [RULE3]
    else $error("filled buffer not valid or not rotated");
endmodule // fbp_flash_bus_port
`default_nettype wire

/* File: hw/fbp_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface fbp_buf_if;
  logic [15:0] look_line;
  logic [15:0] peek_line;
  logic look_hit;
  logic look_idx;
  logic [255:0] look_data;
  logic peek_hit;
  logic [1:0] valid;
  logic fill_en;
  logic fill_idx;
  logic [15:0] fill_line;
  logic [255:0] fill_data;
  logic touch;
  logic flush;
  modport core (output look_line, peek_line, fill_en, fill_line,
    fill_data, touch, flush, input look_hit, look_idx, look_data,
    peek_hit, valid, fill_idx);
  modport store (input look_line, peek_line, fill_en, fill_line,
    fill_data, touch, flush, output look_hit, look_idx, look_data,
    peek_hit, valid, fill_idx);
endinterface
interface fbp_cfg_if;
  logic pf_en;
  logic lim_en;
  logic [1:0] lim_mst;
  logic instr_en;
  logic data_en;
  logic flush;
  logic [1:0] valid;
  logic busy;
  logic pf_pend;
  logic [15:0] hits;
  logic [15:0] misses;
  modport regs (output pf_en, lim_en, lim_mst, instr_en, data_en,
    flush, input valid, busy, pf_pend, hits, misses);
  modport core (input pf_en, lim_en, lim_mst, instr_en, data_en,
    flush, output valid, busy, pf_pend, hits, misses);
endinterface
`default_nettype wire

/* File: hw/fbp_line_buf.sv */
`timescale 1ns/1ps
`default_nettype none
module fbp_line_buf (
  input wire logic clk,
  input wire logic rst_n,
  fbp_buf_if.store bi
);
  logic [255:0] line_data [2];
  logic [15:0] tag [2];
  logic [1:0] valid;
  logic lru;
  logic [1:0] lh;
  logic [1:0] ph;

  function automatic logic tag_hit(input logic v,
    input logic [15:0] t, input logic [15:0] l);
    tag_hit = v && (t == l);
  endfunction

  // ------------------------------------------------------------
  // lookup
  // ------------------------------------------------------------
  for (genvar g = 0; g < fbp_pkg::NBUF; g++) begin : g_cmp
    assign lh[g] = tag_hit(valid[g], tag[g], bi.look_line); // [RULE13]
    assign ph[g] = tag_hit(valid[g], tag[g], bi.peek_line);
  end
  assign bi.look_hit = |lh;
  assign bi.look_idx = lh[1];
  assign bi.look_data = line_data[lh[1]];
  assign bi.peek_hit = |ph;
  assign bi.valid = valid;
  assign bi.fill_idx = lru;

  // ------------------------------------------------------------
  // fill and replacement
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      valid <= 2'h0; // [RULE13]
      lru <= 1'b0;
    end else begin
      if (bi.flush) begin
        valid <= 2'h0;
      end
      if (bi.fill_en) begin
        valid[lru] <= 1'b1;
        lru <= ~lru;
      end else if (bi.touch) begin
        lru <= ~bi.look_idx;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (bi.fill_en) begin
      line_data[lru] <= bi.fill_data; // [RULE3]
      tag[lru] <= bi.fill_line;
    end
  end
endmodule // fbp_line_buf
`default_nettype wire

/* File: hw/fbp_pkg.sv */
`default_nettype none
package fbp_pkg;
  // ------------------------------------------------------------
  // array geometry
  // ------------------------------------------------------------
  localparam int ADDR_W = 21;
  localparam int LINE_W = 256;
  localparam int BEAT_W = 64;
  localparam int LINE_AW = 16;
  localparam int NBUF = 2;
  localparam int MST_W = 2;
  localparam logic [20:0] ARR_BYTES = 21'h18_0000;
  localparam logic [15:0] LAST_LINE = 16'hBFFF;
  localparam int LINE_LSB = 5;
  localparam int BEAT_LSB = 3;
  localparam int MISS_WAITS = 3;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_HITS = 8'h08;
  localparam logic [7:0] OFF_MISSES = 8'h0C;
  localparam int CTRL_PF_EN = 0;
  localparam int CTRL_LIM_EN = 1;
  localparam int CTRL_LIM_MST = 2;
  localparam int CTRL_INSTR_EN = 4;
  localparam int CTRL_DATA_EN = 5;
  localparam int CTRL_FLUSH = 6;
  localparam logic [5:0] CTRL_RST = 6'h31;
  localparam int STAT_VALID = 0;
  localparam int STAT_BUSY = 2;
  localparam int STAT_PF_PEND = 3;
  typedef enum logic [1:0] {
    FBP_IDLE, FBP_DWAIT, FBP_DSEND, FBP_PWAIT
  } fbp_state_t;
endpackage
`default_nettype wire
